// ==== verilog/rpd_defines.svh ====
// register map, field positions and page codes for the remote-power discovery block
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH

`define RPD_REG_DISC      5'h1B
`define RPD_BIT_EN        6
`define RPD_BIT_PWR       4
`define RPD_BIT_STD       3
`define RPD_BIT_LFIT      2
`define RPD_EN_RESET      1'h0
`define RPD_LAST_PAGE     3'h4
`define RPD_MSG_PAGE      16'hA005
`define RPD_USER_PAGE     16'h8000
`define RPD_NULL_PAGE     16'h2001
`define RPD_NP_CMP_MASK   16'h27FF
`define RPD_LFSR_WIDTH    11
`define RPD_LFSR_TAPS     11'h500

`endif

// ==== verilog/rpd_pkg.sv ====
// types shared by the remote-power discovery block
package rpd_pkg;

  typedef enum logic [2:0] {
    RPD_IDLE,
    RPD_WAIT_BASE,
    RPD_SEND_NP,
    RPD_SEND_NULL,
    RPD_FOUND,
    RPD_HALT
  } rpd_state_t;

  typedef struct packed {
    logic        nlp;
    logic        mlt3;
    logic        base_page;
    logic        base_np;
    logic        next_page;
    logic [15:0] np_word;
    logic        inhibit_timeout_flag;
    logic        parallel_det;
  } rpd_rx_t;

  typedef struct packed {
    logic        np_valid;
    logic [15:0] np_word;
  } rpd_tx_t;

endpackage : rpd_pkg

// ==== verilog/rpd_lfsr.sv ====
// free-running random generator, loaded with a seed once after reset
`include "rpd_defines.svh"

module rpd_lfsr #(
  parameter int               WIDTH = `RPD_LFSR_WIDTH,
  parameter logic [WIDTH-1:0] TAPS  = `RPD_LFSR_TAPS
) (
  input  wire logic             CLOCK,
  input  wire logic             NRST,
  input  wire logic             LOAD,
  input  wire logic [WIDTH-1:0] SEED,
  output logic      [WIDTH-1:0] VALUE
);

  logic [WIDTH-1:0] state_ff;
  logic [WIDTH-1:0] nxt_state;
  wire              feedback = ^(state_ff & TAPS);

  // an all-zero seed would lock the register, so force a one in
  assign nxt_state = LOAD ? (SEED | {{(WIDTH-1){1'b0}}, 1'b1}) : {state_ff[WIDTH-2:0], feedback};
  assign VALUE     = state_ff;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : rpd_lfsr

// ==== verilog/rpd_discovery.sv ====
// per-port remote-power discovery riding on auto-negotiation next pages
`include "rpd_defines.svh"

module rpd_discovery #(
  parameter int ADDR_WIDTH = 5,
  parameter int RAND_WIDTH = `RPD_LFSR_WIDTH
) (
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  input  wire logic [ADDR_WIDTH-1:0] PHY_ADDR,
  input  wire logic [4:0]            MGMT_REG,
  input  wire logic                  MGMT_WR,
  input  wire logic                  MGMT_RD,
  input  wire logic [15:0]           MGMT_WDATA,
  output logic      [15:0]           MGMT_RDATA,
  input  wire logic                  AN_ENABLE,
  input  wire logic                  AN_RESTART,
  input  wire logic                  LINK_UP,
  input  wire rpd_pkg::rpd_rx_t      RX,
  output rpd_pkg::rpd_tx_t           TX,
  output logic                       ADV_NP_ABILITY,
  output logic                       MANUAL_NP_ALLOW,
  output logic                       AN_RESTART_REQ,
  output logic                       RESOLVE_BASE
);

  ////////////////////////////////////////////////////////////////////////////
  // management register decode

  logic                   en_ff;
  logic                   pwr_ff;
  logic                   std_ff;
  logic                   lfit_ff;
  logic                   link_ff;
  logic                   seeded_ff;
  logic [2:0]             idx_ff;
  logic [RAND_WIDTH-1:0]  pool_ff [0:3];
  logic [RAND_WIDTH-1:0]  rand_val;
  rpd_pkg::rpd_state_t    st_ff;
  rpd_pkg::rpd_state_t    nxt_st;
  logic [2:0]             nxt_idx;
  logic [15:0]            page_word;
  logic [15:0]            nxt_rdata;
  logic [15:0]            rdata_ff;

  wire reg_hit   = MGMT_REG == `RPD_REG_DISC;
  wire wr_hit    = MGMT_WR & reg_hit;
  wire rd_hit    = MGMT_RD & reg_hit;
  wire disc_on   = en_ff & AN_ENABLE;
  wire clr_all   = AN_RESTART | ~AN_ENABLE;
  wire lfit_hit  = RX.inhibit_timeout_flag & ~LINK_UP & AN_ENABLE;
  wire in_disc   = (st_ff == rpd_pkg::RPD_WAIT_BASE) | (st_ff == rpd_pkg::RPD_SEND_NP)
                 | (st_ff == rpd_pkg::RPD_SEND_NULL);
  wire abort     = in_disc & (LINK_UP | RX.parallel_det);
  wire np_match  = (RX.np_word & `RPD_NP_CMP_MASK) == (page_word & `RPD_NP_CMP_MASK);
  wire np_rx     = (st_ff == rpd_pkg::RPD_SEND_NP) & RX.next_page;
  wire all_match = np_rx & np_match & (idx_ff == `RPD_LAST_PAGE);
  wire mismatch  = np_rx & ~np_match;
  wire no_np     = (st_ff == rpd_pkg::RPD_WAIT_BASE) & RX.base_page & ~RX.base_np;
  wire line_std  = (st_ff == rpd_pkg::RPD_WAIT_BASE) & (RX.nlp | RX.mlt3);
  wire null_done = (st_ff == rpd_pkg::RPD_SEND_NULL) & RX.next_page;
  wire kill      = ~disc_on | AN_RESTART | lfit_hit;

  wire set_std   = ~kill & ~abort & (line_std | no_np | mismatch);
  wire set_pwr   = ~kill & ~abort & all_match;
  wire set_lfit  = lfit_hit & en_ff;

  assign ADV_NP_ABILITY  = disc_on;
  assign MANUAL_NP_ALLOW = ~disc_on;
  assign MGMT_RDATA      = rdata_ff;

  // one register set per port instance
  assign nxt_rdata = rd_hit ? {9'h000, en_ff, 1'b0, pwr_ff, std_ff, lfit_ff, 2'h0} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // page generation

  // random user fields seeded from port address
  rpd_lfsr #(
    .WIDTH (RAND_WIDTH)
  ) u_lfsr (
    .CLOCK (CLOCK),
    .NRST  (NRST),
    .LOAD  (~seeded_ff),
    .SEED  ({{(RAND_WIDTH-ADDR_WIDTH){1'b0}}, PHY_ADDR}),
    .VALUE (rand_val)
  );

  // message page then four user pages
  assign page_word = (idx_ff == 3'h0) ? `RPD_MSG_PAGE
                   : (`RPD_USER_PAGE | {{(16-RAND_WIDTH){1'b0}}, pool_ff[idx_ff[1:0] - 2'h1]});

  ////////////////////////////////////////////////////////////////////////////
  // discovery sequencer

  always_comb begin
    nxt_st  = st_ff;
    nxt_idx = idx_ff;
    if (kill) begin
      // restart follows the enables, the idle state re-enters discovery
      nxt_st = rpd_pkg::RPD_IDLE;
    end else if (abort) begin
      nxt_st = rpd_pkg::RPD_HALT;
    end else begin
      case (st_ff)
        rpd_pkg::RPD_IDLE: begin
          // no action while link is up
          if (!LINK_UP) begin
            nxt_st  = rpd_pkg::RPD_WAIT_BASE;
            nxt_idx = 3'h0;
          end
        end
        rpd_pkg::RPD_WAIT_BASE: begin
          if (line_std || no_np) begin
            nxt_st = rpd_pkg::RPD_HALT;
          end else if (RX.base_page) begin
            nxt_st = rpd_pkg::RPD_SEND_NP;
          end
        end
        rpd_pkg::RPD_SEND_NP: begin
          // first mismatch ends with a null page
          if (mismatch) begin
            nxt_st = rpd_pkg::RPD_SEND_NULL;
          end else if (all_match) begin
            nxt_st = rpd_pkg::RPD_FOUND;
          end else if (np_rx) begin
            nxt_idx = idx_ff + 3'h1;
          end
        end
        rpd_pkg::RPD_SEND_NULL: begin
          if (null_done) begin
            nxt_st = rpd_pkg::RPD_HALT;
          end
        end
        rpd_pkg::RPD_FOUND: nxt_st = rpd_pkg::RPD_FOUND;
        rpd_pkg::RPD_HALT: begin
          // a dropped link lets discovery run again
          if (link_ff && !LINK_UP) begin
            nxt_st = rpd_pkg::RPD_IDLE;
          end
        end
        default: nxt_st = rpd_pkg::RPD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and status flops

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_ff          <= rpd_pkg::RPD_IDLE;
      idx_ff         <= 3'h0;
      link_ff        <= 1'b0;
      seeded_ff      <= 1'b0;
      rdata_ff       <= 16'h0000;
      AN_RESTART_REQ <= 1'b0;
      RESOLVE_BASE   <= 1'b0;
    end else begin
      st_ff          <= nxt_st;
      idx_ff         <= nxt_idx;
      link_ff        <= LINK_UP;
      seeded_ff      <= 1'b1;
      rdata_ff       <= nxt_rdata;
      AN_RESTART_REQ <= lfit_hit;
      RESOLVE_BASE   <= ~kill & ~abort & null_done;
    end
  end

  // pool keeps sampling the free-running generator until a discovery starts
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pool_ff <= '{default: '0};
    end else if (st_ff == rpd_pkg::RPD_IDLE) begin
      pool_ff <= '{pool_ff[1], pool_ff[2], pool_ff[3], rand_val};
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      TX <= '0;
    end else if (st_ff == rpd_pkg::RPD_SEND_NULL) begin
      TX <= '{np_valid: 1'b1, np_word: `RPD_NULL_PAGE};
    end else begin
      TX <= '{np_valid: (st_ff == rpd_pkg::RPD_SEND_NP) | (st_ff == rpd_pkg::RPD_FOUND), np_word: page_word};
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      en_ff   <= `RPD_EN_RESET;
      pwr_ff  <= 1'b0;
      std_ff  <= 1'b0;
      lfit_ff <= 1'b0;
    end else begin
      // enable held until software clears it
      if (wr_hit) begin
        en_ff <= MGMT_WDATA[`RPD_BIT_EN];
      end
      // power-found cleared by restart or negotiation off
      pwr_ff  <= set_pwr | (pwr_ff & ~clr_all);
      std_ff  <= set_std | (std_ff & ~(rd_hit | ~en_ff | LINK_UP | clr_all));
      lfit_ff <= set_lfit | (lfit_ff & ~(rd_hit | ~en_ff | LINK_UP | clr_all));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_last_match;
    all_match && !kill && !abort;
  endsequence

  sequence s_found_held;
    pwr_ff && st_ff == rpd_pkg::RPD_FOUND ##1 TX.np_valid;
  endsequence

  a_adv_follows_write: assert property (wr_hit && MGMT_WDATA[`RPD_BIT_EN] && AN_ENABLE |=> ADV_NP_ABILITY)
    else $error("base page did not advertise next pages after enable write");
  a_manual_np_locked: assert property (ADV_NP_ABILITY |-> !MANUAL_NP_ALLOW)
    else $error("manual next pages allowed during discovery");
  a_power_found: assert property (s_last_match |=> s_found_held)
    else $error("power-found not set or last page not repeated");
  a_power_cleared: assert property (AN_RESTART && !set_pwr |=> !pwr_ff)
    else $error("power-found survived restart");
  a_abort_no_power: assert property (abort && !pwr_ff |=> !pwr_ff)
    else $error("aborted discovery set power-found");
  a_std_read_clear: assert property (rd_hit && std_ff && !set_std |=> MGMT_RDATA[`RPD_BIT_STD] && !std_ff)
    else $error("standard bit not returned then cleared on read");
  a_lfit_restart: assert property (lfit_hit && en_ff |=> AN_RESTART_REQ && lfit_ff && st_ff == rpd_pkg::RPD_IDLE)
    else $error("inhibit expiry did not restart and flag");
  a_enable_holds: assert property (en_ff && !wr_hit |=> en_ff)
    else $error("discovery enable dropped by itself");
  a_wait_link_down: assert property (st_ff == rpd_pkg::RPD_IDLE && LINK_UP |=> st_ff == rpd_pkg::RPD_IDLE)
    else $error("discovery started while link up");
  a_null_after_miss: assert property (mismatch && !kill && !abort |=> st_ff == rpd_pkg::RPD_SEND_NULL
                                      ##1 TX.np_word == `RPD_NULL_PAGE)
    else $error("mismatch did not send null page");

endmodule : rpd_discovery

// ==== verification/rpd_partner.sv ====
// link partner model: base page, echoed next pages, legacy signalling, timer events
module rpd_partner (
  input  wire logic             clock,
  input  wire logic             go,
  input  wire logic [2:0]       kind,
  input  wire logic [2:0]       bad,
  input  wire rpd_pkg::rpd_tx_t tx,
  output rpd_pkg::rpd_rx_t      rx,
  output logic                  busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // settle gap first: the page on the wire lags the event by four cycles
  task automatic echo(input logic flip);
    repeat (4) @(posedge clock);
    rx.np_word   <= tx.np_word ^ {15'h0000, flip};
    rx.next_page <= 1'b1;
    @(posedge clock);
    rx.next_page <= 1'b0;
    // released word lines never keep the last value
    rx.np_word   <= ~rx.np_word;
  endtask : echo

  initial begin : run
    int i;
    rx   = '0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy            <= 1'b1;
        rx.nlp          <= (kind == 3'h2);
        rx.mlt3         <= (kind == 3'h3);
        rx.inhibit_timeout_flag <= (kind == 3'h4);
        rx.base_page    <= (kind == 3'h0 || kind == 3'h1 || kind == 3'h5);
        rx.base_np      <= (kind != 3'h1);
        @(posedge clock);
        rx.nlp          <= 1'b0;
        rx.mlt3         <= 1'b0;
        rx.inhibit_timeout_flag <= 1'b0;
        rx.base_page    <= 1'b0;
        if (kind == 3'h5) begin
          echo(1'b0);
          rx.parallel_det <= 1'b1;
          @(posedge clock);
          rx.parallel_det <= 1'b0;
        end else if (kind == 3'h0) begin
          for (i = 0; i < 5 && i <= bad; i++) echo(i == bad);
          // a mismatch is followed by the null page, answered once more
          if (bad < 3'h5) echo(1'b0);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : rpd_partner

// ==== verification/tb.sv ====
// self-checking bench for the remote-power discovery block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             CLOCK, NRST, MGMT_WR, MGMT_RD, AN_ENABLE, AN_RESTART, LINK_UP, go, busy;
  logic             ADV_NP_ABILITY, MANUAL_NP_ALLOW, AN_RESTART_REQ, RESOLVE_BASE;
  logic [4:0]       PHY_ADDR, MGMT_REG;
  logic [15:0]      MGMT_WDATA, MGMT_RDATA, seed;
  logic [2:0]       kind, bad;
  rpd_pkg::rpd_rx_t RX;
  rpd_pkg::rpd_tx_t TX;
  logic [15:0]      pages[$];
  int               fails, n_compared, n_res, n_req, cycles, k, en_m, pwr_m, std_m, lfit_m;

  rpd_discovery u_dut (.CLOCK(CLOCK), .NRST(NRST), .PHY_ADDR(PHY_ADDR), .MGMT_REG(MGMT_REG),
    .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD), .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA),
    .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART), .LINK_UP(LINK_UP), .RX(RX), .TX(TX),
    .ADV_NP_ABILITY(ADV_NP_ABILITY), .MANUAL_NP_ALLOW(MANUAL_NP_ALLOW),
    .AN_RESTART_REQ(AN_RESTART_REQ), .RESOLVE_BASE(RESOLVE_BASE));
  rpd_partner u_partner (.clock(CLOCK), .go(go), .kind(kind), .bad(bad), .tx(TX), .rx(RX), .busy(busy));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // pages are recorded as the partner answers them, so equal random pages are not merged
  always @(posedge CLOCK) begin
    cycles++;
    if (RX.next_page && TX.np_valid) pages.push_back(TX.np_word);
    if (RESOLVE_BASE) n_res++;
    if (AN_RESTART_REQ) n_req++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [15:0] exp_reg();
    return 16'((en_m << 6) | (pwr_m << 4) | (std_m << 3) | (lfit_m << 2));
  endfunction : exp_reg

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [15:0] d);
    @(posedge CLOCK);
    MGMT_REG   <= 5'h1B;
    MGMT_WDATA <= d;
    MGMT_WR    <= 1'b1;
    @(posedge CLOCK);
    MGMT_WR    <= 1'b0;
    en_m = d[6];
    if (!d[6]) {std_m, lfit_m} = 0;
  endtask : wr

  // read data shows for one cycle after the taking edge
  task automatic rd(input logic [4:0] r, input logic [15:0] want);
    @(posedge CLOCK);
    MGMT_REG <= r;
    MGMT_RD  <= 1'b1;
    @(posedge CLOCK);
    MGMT_RD  <= 1'b0;
    #1 check(MGMT_RDATA, want);
    if (r == 5'h1B) {std_m, lfit_m} = 0;
  endtask : rd

  task automatic restart();
    @(posedge CLOCK);
    AN_RESTART <= 1'b1;
    @(posedge CLOCK);
    AN_RESTART <= 1'b0;
    {pwr_m, std_m, lfit_m} = 0;
  endtask : restart

  task automatic run(input logic [2:0] kd, input logic [2:0] bd);
    pages.delete();
    {n_res, n_req, k} = 0;
    seed = lfsr(seed);
    @(posedge CLOCK);
    {kind, bad, go} <= {kd, bd, 1'b1};
    @(posedge CLOCK);
    go <= 1'b0;
    while ((busy || k < 2) && k < 300) begin
      @(posedge CLOCK);
      k++;
    end
    repeat (4) @(posedge CLOCK);
  endtask : run

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {fails, n_compared, cycles, en_m, pwr_m, std_m, lfit_m} = 0;
    seed = 16'h000D;
    {NRST, MGMT_WR, MGMT_RD, AN_RESTART, LINK_UP, go} = 0;
    {MGMT_REG, MGMT_WDATA, kind, bad} = 0;
    AN_ENABLE = 1'b1;
    PHY_ADDR  = seed[4:0];
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    rd(5'h1B, 16'h0000);
    check({15'h0000, MANUAL_NP_ALLOW}, 16'h0001);
    rd(5'h00, 16'h0000);
    seed = lfsr(seed);
    wr(seed | 16'h0040);
    #1 check({15'h0000, ADV_NP_ABILITY}, 16'h0001);
    check({15'h0000, MANUAL_NP_ALLOW}, 16'h0000);
    rd(5'h1B, exp_reg());
    AN_ENABLE <= 1'b0;
    @(posedge CLOCK);
    #1 check({15'h0000, ADV_NP_ABILITY}, 16'h0000);
    AN_ENABLE <= 1'b1;
    restart();
    run(3'h0, 3'h5);
    check(16'(pages.size()), 16'h0005);
    check(pages[0], 16'hA005);
    for (int i = 1; i < 5; i++) check(pages[i] & 16'hF800, 16'h8000);
    pwr_m = 1;
    rd(5'h1B, exp_reg());
    repeat (10) @(posedge CLOCK);
    #1 check(TX.np_word, pages[4]);
    restart();
    rd(5'h1B, exp_reg());
    for (int b = 0; b < 5; b++) begin
      restart();
      run(3'h0, 3'(b));
      std_m = 1;
      check(16'(pages.size()), 16'(b + 2));
      check(pages[$], 16'h2001);
      check(16'(n_res), 16'h0001);
      check(16'(n_req), 16'h0000);
      rd(5'h1B, exp_reg());
      rd(5'h1B, exp_reg());
    end
    for (int kd = 1; kd < 4; kd++) begin
      restart();
      run(3'(kd), 3'h5);
      std_m = 1;
      rd(5'h1B, exp_reg());
    end
    restart();
    // no link in time, supply off
    run(3'h4, 3'h5);
    lfit_m = 1;
    check(16'(n_req), 16'h0001);
    rd(5'h1B, exp_reg());
    rd(5'h1B, exp_reg());
    restart();
    run(3'h5, 3'h5);
    rd(5'h1B, exp_reg());
    LINK_UP <= 1'b1;
    wr(16'h0000);
    wr(16'h0040);
    run(3'h0, 3'h5);
    check(16'(pages.size()), 16'h0000);
    LINK_UP <= 1'b0;
    restart();
    run(3'h2, 3'h5);
    wr(16'h0000);
    rd(5'h1B, exp_reg());
    print_verdict();
  end
endmodule : tb
